// [hdl/tsadc_pkg.sv]
package tsadc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TMR_W = 16;
  localparam int ADC_W = 10;
  localparam int RES_SHIFT = 6;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

  // Control field positions
  localparam int CTRL_SNOOZE_EN_BIT = 0;
  localparam int CTRL_CONV_EN_BIT = 1;
  localparam int CTRL_TMR_START_BIT = 2;
  localparam int CTRL_LINK_EN_BIT = 3;

  // Status field positions
  localparam int STAT_END_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_MODE_LSB = 4;

  // Timing of the wake interval
  localparam int OSC_HZ = 15000;
  localparam int INTERVAL_S = 4;
  localparam int INTERVAL_TICKS = OSC_HZ * INTERVAL_S;

  // Reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [TMR_W-1:0] RELOAD_RESET = TMR_W'(INTERVAL_TICKS - 1);
  localparam logic [ADC_W-1:0] RESULT_RESET = 10'h000;

  typedef enum logic [2:0] {
    TSADC_NORMAL = 3'b000,
    TSADC_STOP = 3'b001,
    TSADC_STOP_WAIT = 3'b010,
    TSADC_SNOOZE = 3'b011,
    TSADC_CONV = 3'b100
  } tsadc_mode_t;

  typedef struct packed {
    logic link_en;
    logic tmr_start;
    logic conv_en;
    logic snooze_enable;
  } tsadc_ctrl_t;

endpackage

// [hdl/tsadc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module tsadc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule
`default_nettype wire

// [hdl/tsadc_top.sv]
// Notes on behaviour
// - The 16-bit wake interval timer is the only conversion activation source.
// - Timer counts low-speed oscillator ticks, requesting once every four seconds.
// - Timer underflow reaches the converter as hardware trigger via event link unit.
// - Stop with snooze_enable and conv_en set parks converter in standby, chip stays stopped.
// - Trigger in standby moves chip into snooze and starts a conversion.
// - Snooze conversion completes while the core clock stays off.
// - Conversion end in snooze returns the chip to normal mode.
// - Conversion end writes the result register and raises the end interrupt.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tsadc_top
  import tsadc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_osc_clock,
  input wire logic stop_req,
  input wire logic wake_req,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [ADC_W-1:0] conv_data,
  output logic conversion_end_irq,
  output logic core_clk_en,
  output logic [2:0] chip_mode
);

  tsadc_ctrl_t ctrl_ff;
  logic [TMR_W-1:0] reload_ff;
  logic [TMR_W-1:0] count_ff;
  logic [ADC_W-1:0] conversion_result_reg_ff;
  logic end_flag_ff;
  tsadc_mode_t mode_ff;
  tsadc_mode_t nxt_mode;
  logic underflow_ff;
  logic osc_prev_ff;
  logic done_prev_ff;
  logic conv_start_ff;
  logic irq_ff;
  logic core_clk_en_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  logic osc_sync;
  logic done_sync;

  // Both come from outside pclk: the oscillator and the analog macro
  tsadc_sync u_osc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(low_speed_osc_clock),
    .sync_out(osc_sync)
  );

  tsadc_sync u_done_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(conv_done),
    .sync_out(done_sync)
  );

  // Bus decode
  wire access = psel & penable;
  wire wr_en = access & pwrite & pready_ff;
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_reload = (paddr == OFF_RELOAD);
  wire hit_count = (paddr == OFF_COUNT);
  wire hit_result = (paddr == OFF_RESULT);
  wire hit_status = (paddr == OFF_STATUS);
  wire hit_any = hit_ctrl | hit_reload | hit_count | hit_result | hit_status;
  wire wr_ctrl = wr_en & hit_ctrl;
  wire wr_reload = wr_en & hit_reload;
  wire clr_end = wr_en & hit_status & pwdata[STAT_END_BIT];

  // Timer and event path
  wire osc_rise = osc_sync & ~osc_prev_ff;
  wire count_zero = (count_ff == {TMR_W{1'b0}});
  wire nxt_underflow = ctrl_ff.tmr_start & osc_rise & count_zero;
  // The link only forwards the timer event; no other source reaches the converter
  wire hw_trigger = ctrl_ff.link_en & underflow_ff;

  // Conversion tracking
  wire busy = (mode_ff == TSADC_SNOOZE) | (mode_ff == TSADC_CONV);
  wire done_rise = done_sync & ~done_prev_ff;
  wire conv_complete = busy & done_rise;
  // Plain stop parks the converter as well, so a link event is dropped there
  wire trig_mode = (mode_ff == TSADC_NORMAL) | (mode_ff == TSADC_STOP_WAIT);
  wire trig_take = hw_trigger & ctrl_ff.conv_en & trig_mode & ~busy;

  wire [TMR_W-1:0] nxt_count = !ctrl_ff.tmr_start ? reload_ff :
                               !osc_rise ? count_ff :
                               count_zero ? reload_ff :
                               count_ff - 16'h0001;

  wire nxt_end_flag = conv_complete | (end_flag_ff & ~clr_end);

  wire [DATA_W-1:0] status_word = {
    {(DATA_W - STAT_MODE_LSB - 3){1'b0}},
    mode_ff,
    {(STAT_MODE_LSB - 2){1'b0}},
    busy,
    end_flag_ff
  };

  // Result sits left-justified, so software drops the low six bits
  wire [DATA_W-1:0] result_word = {
    {(DATA_W - ADC_W - RES_SHIFT){1'b0}},
    conversion_result_reg_ff,
    {RES_SHIFT{1'b0}}
  };

  wire [DATA_W-1:0] rd_word = hit_ctrl ? {{(DATA_W - 4){1'b0}}, ctrl_ff} :
                              hit_reload ? {{(DATA_W - TMR_W){1'b0}}, reload_ff} :
                              hit_count ? {{(DATA_W - TMR_W){1'b0}}, count_ff} :
                              hit_result ? result_word :
                              hit_status ? status_word :
                              32'h0000_0000;

  wire first_access = access & ~pready_ff;

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      TSADC_NORMAL: begin
        if (trig_take) begin
          nxt_mode = TSADC_CONV;
        end else if (stop_req) begin
          if (ctrl_ff.snooze_enable & ctrl_ff.conv_en) begin
            nxt_mode = TSADC_STOP_WAIT;
          end else begin
            nxt_mode = TSADC_STOP;
          end
        end
      end
      TSADC_STOP: begin
        if (wake_req) begin
          nxt_mode = TSADC_NORMAL;
        end
      end
      TSADC_STOP_WAIT: begin
        if (trig_take) begin
          nxt_mode = TSADC_SNOOZE;
        end else if (wake_req) begin
          nxt_mode = TSADC_NORMAL;
        end
      end
      TSADC_SNOOZE: begin
        // Core stays asleep; other wake sources wait for the conversion
        if (conv_complete) begin
          nxt_mode = TSADC_NORMAL;
        end
      end
      TSADC_CONV: begin
        if (conv_complete) begin
          nxt_mode = TSADC_NORMAL;
        end
      end
      default: begin
        nxt_mode = TSADC_NORMAL;
      end
    endcase
  end

  wire nxt_core_clk_en = (nxt_mode == TSADC_NORMAL) | (nxt_mode == TSADC_CONV);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= tsadc_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= tsadc_ctrl_t'(pwdata[3:0]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_ff <= RELOAD_RESET;
    end else begin
      if (wr_reload) begin
        reload_ff <= pwdata[TMR_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= RELOAD_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Reset level matches the idle oscillator sample, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_ff <= 1'b0;
    end else begin
      osc_prev_ff <= osc_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_ff <= 1'b0;
    end else begin
      underflow_ff <= nxt_underflow;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= TSADC_NORMAL;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clk_en_ff <= 1'b1;
    end else begin
      core_clk_en_ff <= nxt_core_clk_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= trig_take;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_prev_ff <= 1'b0;
    end else begin
      done_prev_ff <= done_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result_reg_ff <= RESULT_RESET;
    end else begin
      if (conv_complete) begin
        conversion_result_reg_ff <= conv_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_flag_ff <= 1'b0;
    end else begin
      end_flag_ff <= nxt_end_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= conv_complete;
    end
  end

  // Two-cycle access phase so read data can come from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= first_access;
      pslverr_ff <= first_access & ~hit_any;
    end
  end

  // Read data holds between reads; writes leave it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (first_access & ~pwrite) begin
        prdata_ff <= rd_word;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign conv_start = conv_start_ff;
  assign conversion_end_irq = irq_ff;
  assign core_clk_en = core_clk_en_ff;
  assign chip_mode = mode_ff;

endmodule
`default_nettype wire

// [dv/tsadc_analog_src.sv]
`timescale 1ns/1ns
`default_nettype none
module tsadc_analog_src
  import tsadc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_start,
  input wire logic [ADC_W-1:0] level,
  input wire logic [15:0] delay,
  output logic conv_done,
  output logic [ADC_W-1:0] conv_data
);
  logic [15:0] cnt;
  logic busy;
  // Result held nine cycles after done, then inverted so a late sample cannot match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 16'h0000;
      conv_done <= 1'b0;
      conv_data <= '1;
    end else if (conv_start && !busy) begin
      busy <= 1'b1;
      cnt <= delay;
    end else if (busy && cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end else if (busy && !conv_done) begin
      conv_done <= 1'b1;
      conv_data <= level;
      cnt <= 16'h0008;
    end else if (busy) begin
      busy <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end
  end
endmodule
`default_nettype wire

// [dv/tsadc_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module tsadc_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic conversion_end_irq,
  input wire logic core_clk_en,
  input wire logic [2:0] chip_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait_core; chip_mode == 3'd2 |-> !core_clk_en; endproperty
  a_wait_core: assert property (p_wait_core) else $error("core clock on in standby");
  property p_stop_nostart; chip_mode == 3'd1 |-> !conv_start; endproperty
  a_stop_nostart: assert property (p_stop_nostart) else $error("start in plain stop");
  property p_enter; $past(chip_mode) == 3'd2 && chip_mode == 3'd3 |-> conv_start; endproperty
  a_enter: assert property (p_enter) else $error("snooze without start");
  property p_start_mode; conv_start |-> chip_mode == 3'd3 || chip_mode == 3'd4; endproperty
  a_start_mode: assert property (p_start_mode) else $error("start outside conversion");
  property p_snooze_core; chip_mode == 3'd3 |-> !core_clk_en; endproperty
  a_snooze_core: assert property (p_snooze_core) else $error("core woken in snooze");
  property p_exit;
    chip_mode == 3'd3 && $rose(conv_done)
      |-> ##[3:5] (conversion_end_irq && chip_mode == 3'd0 && core_clk_en);
  endproperty
  a_exit: assert property (p_exit) else $error("no return to normal");
  property p_irq_pulse; conversion_end_irq |=> !conversion_end_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("end irq too long");
  property p_one_start; conv_start |=> !conv_start [*8]; endproperty
  a_one_start: assert property (p_one_start) else $error("second start");
  c_snooze: cover property (conv_start && chip_mode == 3'd3);
  c_irq: cover property (conversion_end_irq);
  c_stop: cover property (chip_mode == 3'd1);
  c_conv: cover property (conv_start && chip_mode == 3'd4);
endmodule
bind tsadc_top tsadc_sva u_sva (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
  .conv_done(conv_done), .conversion_end_irq(conversion_end_irq),
  .core_clk_en(core_clk_en), .chip_mode(chip_mode));
`default_nettype wire

// [dv/tb_timed_snooze_adc_wakeup.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_timed_snooze_adc_wakeup;
  import tsadc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_req, wake_req, e;
  logic conv_start, conv_done, conversion_end_irq, core_clk_en;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [ADC_W-1:0] conv_data, level;
  logic [15:0] delay;
  logic [2:0] chip_mode;
  logic [5:0] osc_cnt;
  int n_mismatch, check_count, n_start, n_irq, n_s;
  int buf_q[$];
  tsadc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_speed_osc_clock(osc_cnt[5]), .stop_req(stop_req),
    .wake_req(wake_req), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .conversion_end_irq(conversion_end_irq),
    .core_clk_en(core_clk_en), .chip_mode(chip_mode));
  tsadc_analog_src u_src (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .level(level), .delay(delay), .conv_done(conv_done), .conv_data(conv_data));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    osc_cnt <= osc_cnt + 6'd1;
    if (conv_start === 1'b1) n_start++;
    if (conversion_end_irq === 1'b1) n_irq++;
  end
  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin n_mismatch++; results(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wt(input bit irq, input logic [2:0] m);
    int i;
    i = 0;
    do begin @(posedge pclk); i++; end
    while (!(irq ? conversion_end_irq === 1'b1 : chip_mode === m) && i < 3000);
    if (!(irq ? conversion_end_irq === 1'b1 : chip_mode === m)) begin
      n_mismatch++;
      results();
    end
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    stop_req = 0; wake_req = 0; level = '0; delay = 16'h0005; osc_cnt = '0;
    void'($urandom(9666));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL, '0); chk(r, 32'h0000_0000);
    apb(1'b0, OFF_RELOAD, '0); chk(r, 32'h0000_EA5F);
    apb(1'b0, 8'h20, '0); chk(32'(e), 32'h0000_0001);
    apb(1'b1, OFF_RELOAD, 32'h0000_EA5F);
    apb(1'b0, OFF_COUNT, '0); chk(r, 32'h0000_EA5F);
    $display("test reset done");
    apb(1'b1, OFF_RELOAD, 32'h0000_0003); // Short interval keeps the run brief
    apb(1'b0, OFF_COUNT, '0); chk(r, 32'h0000_0003);
    for (int k = 0; k < 12; k++) begin
      level <= ADC_W'($urandom);
      delay <= (k == 5) ? 16'h012C : 16'(3 + $urandom % 38); // Slow case spans a trigger
      apb(1'b1, OFF_CTRL, 32'h0000_000F);
      stop_req <= 1'b1; @(posedge pclk); stop_req <= 1'b0;
      wt(1'b0, 3'd2); chk(32'(core_clk_en), 32'h0000_0000);
      wt(1'b0, 3'd3); chk(32'(core_clk_en), 32'h0000_0000);
      wt(1'b1, 3'd0); chk(32'(chip_mode), 32'h0000_0000);
      apb(1'b1, OFF_CTRL, 32'h0000_000E);
      apb(1'b0, OFF_RESULT, '0); chk(r, 32'(level) << RES_SHIFT);
      buf_q.push_back(int'(r >> RES_SHIFT));
      if (buf_q.size() > 10) buf_q.pop_front();
      chk(32'(buf_q[$]), 32'(level));
      apb(1'b0, OFF_STATUS, '0); chk(32'(r[STAT_END_BIT]), 32'h0000_0001);
      apb(1'b1, OFF_STATUS, 32'h0000_0001);
      apb(1'b0, OFF_STATUS, '0); chk(r, 32'h0000_0000);
      $display("test snooze %0d done", k);
    end
    chk(32'(buf_q.size()), 32'h0000_000A);
    level <= ADC_W'($urandom);
    wt(1'b0, 3'd4); chk(32'(core_clk_en), 32'h0000_0001);
    wt(1'b1, 3'd0); chk(32'(chip_mode), 32'h0000_0000);
    apb(1'b0, OFF_RESULT, '0); chk(r, 32'(level) << RES_SHIFT);
    $display("test normal conversion done");
    chk(32'(n_start), 32'(n_irq));
    // Link off: timer keeps running but nothing may start a conversion
    apb(1'b1, OFF_CTRL, 32'h0000_0007);
    stop_req <= 1'b1; @(posedge pclk); stop_req <= 1'b0;
    wt(1'b0, 3'd2);
    n_s = n_start;
    repeat (600) @(posedge pclk);
    chk(32'(n_start), 32'(n_s));
    wake_req <= 1'b1; @(posedge pclk); wake_req <= 1'b0;
    wt(1'b0, 3'd0); chk(32'(core_clk_en), 32'h0000_0001);
    $display("test link off done");
    // Enter plain stop with the link off, then turn it on so triggers reach a stopped chip
    apb(1'b1, OFF_CTRL, 32'h0000_0006);
    stop_req <= 1'b1; @(posedge pclk); stop_req <= 1'b0;
    wt(1'b0, 3'd1);
    apb(1'b1, OFF_CTRL, 32'h0000_000E);
    n_s = n_start;
    repeat (600) @(posedge pclk);
    chk(32'(n_start), 32'(n_s));
    chk(32'(chip_mode), 32'h0000_0001);
    wake_req <= 1'b1; @(posedge pclk); wake_req <= 1'b0;
    wt(1'b0, 3'd0); chk(32'(core_clk_en), 32'h0000_0001);
    $display("test plain stop done");
    results();
  end
endmodule
`default_nettype wire
